/* File: logic/eecl_client.sv */
// Two-wire serial EEPROM client: 512 bytes in two blocks, 16-byte page
// write, self-timed write cycle, sequential reads, upper-half protect pin.
// Assumes an external pull-up resolves SDA from sda_oe; link_clk is a free
// running sampling clock much faster than SCL; sys_rst lasts a few clk edges.
//
// Function
// RULE1 - Bus idle when SDA and SCL high
// RULE2 - SDA fall with SCL high is Start
// RULE3 - SDA rise with SCL high is Stop
// RULE4 - SDA changes only while SCL low
// RULE5 - One SCL pulse per bit, eight per byte
// RULE6 - Receiver pulls SDA low on ninth pulse
// RULE7 - First byte is control, check type field
// RULE8 - Control bit one selects block, address MSB
// RULE9 - Control bit zero: one reads, zero writes
// RULE10 - Ack control only on match and idle
// RULE11 - Mismatch: no ack, ignore until Start
// RULE12 - Second write byte loads low pointer
// RULE13 - Buffer up to 16 bytes, commit on Stop
// RULE14 - Only low four pointer bits increment
// RULE15 - Over 16 bytes wrap within page
// RULE16 - Stop starts write cycle, no acks meanwhile
// RULE17 - Write cycle lasts at most 5 ms
// RULE18 - Ack polling: nack busy, ack when done
// RULE19 - Protect pin inhibits writes to upper half
// RULE20 - Pointer holds last address plus one
// RULE21 - Repeated Start keeps pointer, drops write
// RULE22 - Host ack: increment, send next byte
// RULE23 - Host nack: release SDA, stop sending
`timescale 1ns/10ps
`default_nettype none
`include "eecl_consts.svh"

module eecl_client
  import eecl_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `EECL_TWC_CYCLES, // Write cycle length in clk cycles
  parameter logic [3:0]  DEV_CODE     = 4'h5              // Device type code, value arbitrary
) (
  input  wire logic clk,        // System clock, 125 MHz
  input  wire logic sys_rst,    // Synchronous reset, active high
  input  wire logic link_clk,   // Link sampling clock
  input  wire logic scl_i,      // SCL pin level
  input  wire logic sda_i,      // SDA pin level
  input  wire logic wp_i,       // Write protect pin
  output var  logic sda_o,      // SDA drive level
  output var  logic sda_oe,     // SDA drive enable
  output var  logic write_busy  // Internal write cycle running
);

  eecl_link_t lk_r;     // Link domain state
  eecl_link_t lk_nxt;   // Its next value
  eecl_core_t co_r;     // System domain state
  eecl_core_t co_nxt;   // Its next value
  logic       rst_lm;   // Reset synchroniser stage 1
  logic       rst_l;    // Reset in link domain

  // Carry reset into the link domain; only rst_l reads rst_lm
  always_ff @(posedge link_clk) begin
    rst_lm <= sys_rst;
    rst_l  <= rst_lm;
  end

  // Link domain: bus conditions, byte framing, pointer, page buffer, array
  always_comb begin
    logic start_c;   // Start seen
    logic stop_c;    // Stop seen
    logic rise_c;    // SCL rising
    logic fall_c;    // SCL falling
    logic load_c;    // Fetch next read byte
    logic prot_c;    // Current page is protected
    lk_nxt  = lk_r;
    start_c = 1'b0;
    stop_c  = 1'b0;
    rise_c  = 1'b0;
    fall_c  = 1'b0;
    load_c  = 1'b0;
    prot_c  = 1'b0;
    // Two-stage synchronisers; stage 1 feeds stage 2 only
    lk_nxt.scl_m  = scl_i;
    lk_nxt.scl_s  = lk_r.scl_m;
    lk_nxt.scl_p  = lk_r.scl_s;
    lk_nxt.sda_m  = sda_i;
    lk_nxt.sda_s  = lk_r.sda_m;
    lk_nxt.sda_p  = lk_r.sda_s;
    lk_nxt.wp_m   = wp_i;
    lk_nxt.wp_s   = lk_r.wp_m;
    lk_nxt.done_m = co_r.done_tgl;
    lk_nxt.done_s = lk_r.done_m;
    lk_nxt.done_p = lk_r.done_s;
    lk_nxt.sda_o  = 1'b0;
    // Edge classification on synchronised pins
    start_c = lk_r.scl_s && lk_r.scl_p && lk_r.sda_p && !lk_r.sda_s;  // [RULE2]
    stop_c  = lk_r.scl_s && lk_r.scl_p && !lk_r.sda_p && lk_r.sda_s;  // [RULE3]
    rise_c  = lk_r.scl_s && !lk_r.scl_p;
    fall_c  = !lk_r.scl_s && lk_r.scl_p;
    // Upper block locked while the protect pin is high
    prot_c  = lk_r.wp_s && lk_r.ptr[8];                                // [RULE19]
    // Completion from the timer domain ends the busy window
    if (lk_r.done_s != lk_r.done_p) begin
      lk_nxt.busy = 1'b0;                                              // [RULE18]
    end
    if (stop_c) begin
      // Commit buffered page; a write into the locked half is dropped
      if (lk_r.state == EECL_WDAT && lk_r.any_data && !lk_r.busy && !prot_c) begin
        for (int i = 0; i < `EECL_PAGE_BYTES; i++) begin
          if (lk_r.valid[i]) begin
            lk_nxt.mem[{lk_r.ptr[8:4], i[3:0]}] = lk_r.pbuf[i];       // [RULE13] [RULE15]
          end
        end
        lk_nxt.req_tgl = ~lk_r.req_tgl;                                // [RULE16]
        lk_nxt.busy    = 1'b1;                                         // [RULE16]
      end
      lk_nxt.state    = EECL_IDLE;                                     // [RULE1]
      lk_nxt.sda_oe   = 1'b0;
      lk_nxt.valid    = '0;
      lk_nxt.any_data = 1'b0;
    end else if (start_c) begin
      // Any Start, repeated or not, abandons a pending write but keeps ptr
      lk_nxt.state    = EECL_CTRL;                                     // [RULE7] [RULE21]
      lk_nxt.bitcnt   = `EECL_START_SLOT;                              // [RULE2] [RULE5]
      lk_nxt.sda_oe   = 1'b0;
      lk_nxt.valid    = '0;
      lk_nxt.any_data = 1'b0;
    end else begin
      unique case (lk_r.state)
        EECL_IDLE, EECL_IGN: begin
          // Wait for the next Start; SDA stays released
          lk_nxt.sda_oe = 1'b0;                                        // [RULE11]
        end
        EECL_CTRL, EECL_ADDR, EECL_WDAT: begin
          // Sample data while SCL is high
          if (rise_c && lk_r.bitcnt < `EECL_ACK_SLOT) begin
            lk_nxt.sh = {lk_r.sh[6:0], lk_r.sda_s};                   // [RULE4] [RULE5]
          end
          if (fall_c) begin
            // The start slot only swallows the Start's own SCL fall, then wraps to 0
            if (lk_r.bitcnt < `EECL_LAST_DATA_BIT || lk_r.bitcnt == `EECL_START_SLOT) begin
              lk_nxt.bitcnt = lk_r.bitcnt + 4'h1;                      // [RULE5]
            end else if (lk_r.bitcnt == `EECL_LAST_DATA_BIT) begin
              // Eighth bit in: decide on the acknowledge
              lk_nxt.bitcnt = `EECL_ACK_SLOT;
              lk_nxt.sda_oe = 1'b1;                                    // [RULE6]
              if (lk_r.state == EECL_CTRL) begin
                if (lk_r.sh[`EECL_CTL_CODE_HI:`EECL_CTL_CODE_LO] != DEV_CODE || lk_r.busy) begin
                  // Foreign device or write cycle busy: stay silent
                  lk_nxt.sda_oe = 1'b0;                                // [RULE10] [RULE11] [RULE18]
                  lk_nxt.state  = EECL_IGN;                            // [RULE11]
                end else begin
                  lk_nxt.blk = lk_r.sh[`EECL_CTL_BLK_BIT];             // [RULE8]
                  // Block bit is the pointer MSB, current-address reads too
                  lk_nxt.ptr[8] = lk_r.sh[`EECL_CTL_BLK_BIT];          // [RULE8] [RULE20]
                  lk_nxt.nxt = lk_r.sh[`EECL_CTL_RW_BIT] ? EECL_RDAT : EECL_ADDR; // [RULE9] [RULE10]
                end
              end else if (lk_r.state == EECL_ADDR) begin
                lk_nxt.ptr = {lk_r.blk, lk_r.sh};                      // [RULE8] [RULE12]
                lk_nxt.nxt = EECL_WDAT;
              end else begin
                // Page buffer slot follows the low nibble, which wraps
                lk_nxt.pbuf[lk_r.ptr[3:0]]  = lk_r.sh;                 // [RULE13] [RULE15]
                lk_nxt.valid[lk_r.ptr[3:0]] = 1'b1;
                lk_nxt.ptr[3:0]  = lk_r.ptr[3:0] + 4'h1;               // [RULE14] [RULE20]
                lk_nxt.any_data  = 1'b1;
                lk_nxt.nxt       = EECL_WDAT;
              end
            end else begin
              // Ack pulse over: release and move on
              lk_nxt.bitcnt = '0;
              lk_nxt.sda_oe = 1'b0;                                    // [RULE6]
              lk_nxt.state  = lk_r.nxt;
              load_c        = (lk_r.nxt == EECL_RDAT);                 // [RULE20]
            end
          end
        end
        EECL_RDAT: begin
          // Host acknowledge is sampled in the ninth high phase
          if (rise_c && lk_r.bitcnt == `EECL_ACK_SLOT) begin
            lk_nxt.hack = !lk_r.sda_s;                                 // [RULE22]
          end
          if (fall_c) begin
            if (lk_r.bitcnt < `EECL_LAST_DATA_BIT) begin
              // Next bit goes out only after SCL has dropped
              lk_nxt.bitcnt = lk_r.bitcnt + 4'h1;                      // [RULE5]
              lk_nxt.tx     = {lk_r.tx[6:0], 1'b0};
              lk_nxt.sda_oe = !lk_r.tx[6];                             // [RULE4]
            end else if (lk_r.bitcnt == `EECL_LAST_DATA_BIT) begin
              lk_nxt.bitcnt = `EECL_ACK_SLOT;
              lk_nxt.sda_oe = 1'b0;                                    // [RULE6]
            end else if (lk_r.hack) begin
              load_c = 1'b1;                                           // [RULE22]
            end else begin
              // No acknowledge: leave SDA high for the host's Stop
              lk_nxt.sda_oe = 1'b0;                                    // [RULE23]
              lk_nxt.state  = EECL_IGN;                                // [RULE23]
            end
          end
        end
        default: begin
          lk_nxt.state  = EECL_IDLE;
          lk_nxt.sda_oe = 1'b0;
        end
      endcase
    end
    // Fetch a read byte and step the full nine-bit pointer
    if (load_c) begin
      lk_nxt.bitcnt = '0;
      // Full nine-bit step lets one read run across the block boundary
      lk_nxt.tx     = lk_r.mem[lk_r.ptr];                              // [RULE8] [RULE20]
      lk_nxt.ptr    = lk_r.ptr + 9'h001;                               // [RULE20] [RULE22]
      lk_nxt.sda_oe = !lk_r.mem[lk_r.ptr][7];                          // [RULE4]
    end
  end

  // Link domain register; reset clears the array as well as control state
  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      lk_r     <= '0;
      lk_r.ptr <= `EECL_PTR_RESET;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // System domain: self-timed write cycle, started by a toggle from the link
  always_comb begin
    co_nxt       = co_r;
    co_nxt.req_m = lk_r.req_tgl;
    co_nxt.req_s = co_r.req_m;
    co_nxt.req_p = co_r.req_s;
    if (co_r.req_s != co_r.req_p) begin
      // New commit: time the programming window
      co_nxt.running = 1'b1;
      co_nxt.cnt     = 20'(WRITE_CYCLES - 1);                          // [RULE17]
    end else if (co_r.running) begin
      if (co_r.cnt == `EECL_CNT_RESET) begin
        // Window over; tell the link by toggling back
        co_nxt.running  = 1'b0;
        co_nxt.done_tgl = ~co_r.done_tgl;                              // [RULE17] [RULE18]
      end else begin
        co_nxt.cnt = co_r.cnt - 20'h00001;
      end
    end
  end

  // System domain register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      co_r     <= '0;
      co_r.cnt <= `EECL_CNT_RESET;
    end else begin
      co_r <= co_nxt;
    end
  end

  // Outputs come straight from flip-flops
  always_comb begin
    sda_o      = lk_r.sda_o;
    sda_oe     = lk_r.sda_oe;
    write_busy = co_r.running;
  end

endmodule : eecl_client
`default_nettype wire

/* File: logic/eecl_consts.svh */
// Constants of the two-wire EEPROM client: field positions, sizes, timing.
// Assumes inclusion by its bare name from the design file.
`ifndef EECL_CONSTS_SVH
`define EECL_CONSTS_SVH

// Control byte fields
`define EECL_CTL_RW_BIT    0
`define EECL_CTL_BLK_BIT   1
`define EECL_CTL_CODE_HI   7
`define EECL_CTL_CODE_LO   4

// Bit slot numbers inside one nine-pulse byte frame
`define EECL_LAST_DATA_BIT 4'h7
`define EECL_ACK_SLOT      4'h8
// Slot right after a Start: the Start's own SCL fall carries no bit
`define EECL_START_SLOT    4'hF

// Array and page geometry
`define EECL_MEM_BYTES     512
`define EECL_PAGE_BYTES    16

// Reset values
`define EECL_PTR_RESET     9'h000
`define EECL_CNT_RESET     20'h00000

// Write cycle time and system clock period
`define EECL_TWC_MS        5
`define EECL_CLK_PERIOD_NS 8
// Longest time, so the cycle count rounds down
`define EECL_TWC_CYCLES    ((`EECL_TWC_MS * 1000000) / `EECL_CLK_PERIOD_NS)

`endif

/* File: logic/eecl_pkg.sv */
// Types of the two-wire EEPROM client: link state, per-domain state records.
// Assumes eecl_consts.svh sits on the include path.
`default_nettype none
package eecl_pkg;

  // Byte-level protocol state, Gray along idle-control-address-data-read
  typedef enum logic [2:0] {
    EECL_IDLE = 3'h0,  // Bus free or after Stop
    EECL_CTRL = 3'h1,  // Receiving control byte
    EECL_ADDR = 3'h3,  // Receiving word address
    EECL_WDAT = 3'h2,  // Receiving write data
    EECL_RDAT = 3'h6,  // Transmitting read data
    EECL_IGN  = 3'h4   // Deaf until next Start or Stop
  } eecl_state_t;

  // Whole state of the link-clock domain
  typedef struct packed {
    logic [511:0][7:0] mem;      // Array storage
    logic [15:0][7:0]  pbuf;     // Page buffer
    logic [15:0]       valid;    // Page buffer entries written
    logic [8:0]        ptr;      // Address pointer
    logic [7:0]        sh;       // Receive shifter
    logic [7:0]        tx;       // Transmit shifter
    logic [3:0]        bitcnt;   // Pulse index in byte frame
    eecl_state_t       state;    // Protocol state
    eecl_state_t       nxt;      // State after ack slot
    logic              blk;      // Block select from control byte
    logic              hack;     // Host acknowledged last read byte
    logic              any_data; // Data byte buffered this frame
    logic              busy;     // Write cycle in progress
    logic              req_tgl;  // Write cycle request toggle
    logic              sda_oe;   // Pull SDA low
    logic              sda_o;    // Driven level, always low
    logic              scl_m;    // SCL synchroniser stage 1
    logic              scl_s;    // SCL synchroniser stage 2
    logic              scl_p;    // SCL previous
    logic              sda_m;    // SDA synchroniser stage 1
    logic              sda_s;    // SDA synchroniser stage 2
    logic              sda_p;    // SDA previous
    logic              wp_m;     // Protect pin stage 1
    logic              wp_s;     // Protect pin stage 2
    logic              done_m;   // Done toggle stage 1
    logic              done_s;   // Done toggle stage 2
    logic              done_p;   // Done toggle previous
  } eecl_link_t;

  // Whole state of the system-clock domain
  typedef struct packed {
    logic [19:0] cnt;      // Write cycle timer
    logic        running;  // Timer active
    logic        done_tgl; // Completion toggle
    logic        req_m;    // Request toggle stage 1
    logic        req_s;    // Request toggle stage 2
    logic        req_p;    // Request toggle previous
  } eecl_core_t;

endpackage : eecl_pkg
`default_nettype wire

/* File: tb/eecl_client_assertions.sv */
// Checker for the two-wire EEPROM client, watching its top-level ports only.
// Assumes one clk domain for the write timer and one link_clk domain for the pins.
`timescale 1ns/10ps
`default_nettype none
module eecl_client_checker
  import eecl_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = 625000, // Write cycle length in clk cycles
  parameter logic [3:0]  DEV_CODE     = 4'h5    // Device type code, value arbitrary
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic wp_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic write_busy
);
  logic [19:0] busy_cnt_r; // Clk cycles write_busy has been high
  logic [5:0]  stop_age_r; // Clk cycles since last Stop, saturates so it cannot wrap
  logic [5:0]  lrst_r;     // sys_rst history on link_clk
  wire  logic  lnk_rst;    // Link logic still in or just out of reset
  // The link logic leaves reset some link_clk edges after sys_rst falls
  always_ff @(posedge link_clk) begin
    lrst_r <= {lrst_r[4:0], sys_rst};
  end
  assign lnk_rst = sys_rst || (lrst_r != 6'h00);
  // Helper counters in the clk domain
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_cnt_r <= 20'h00000;
      stop_age_r <= 6'h3F;
    end else begin
      busy_cnt_r <= write_busy ? busy_cnt_r + 20'h00001 : 20'h00000;
      if (scl_i && $rose(sda_i)) stop_age_r <= 6'h00;
      else if (stop_age_r != 6'h3F) stop_age_r <= stop_age_r + 6'h01;
    end
  end
  drive_low_a : assert property (@(posedge link_clk) disable iff (lnk_rst)
    sda_oe |-> !sda_o) else $error("device drives SDA high");
  change_low_a : assert property (@(posedge link_clk) disable iff (lnk_rst)
    scl_i && $past(scl_i) |-> $stable(sda_oe)) else $error("SDA drive changed with SCL high");
  ack_through_a : assert property (@(posedge link_clk) disable iff (lnk_rst)
    sda_oe && $rose(scl_i) |-> sda_oe [*4]) else $error("SDA drive dropped in SCL high");
  start_quiet_a : assert property (@(posedge link_clk) disable iff (lnk_rst)
    scl_i && $fell(sda_i) |-> !sda_oe [*3]) else $error("device drives at Start");
  stop_quiet_a : assert property (@(posedge link_clk) disable iff (lnk_rst)
    scl_i && $rose(sda_i) |=> !sda_oe [*4]) else $error("device drives after Stop");
  busy_nack_a : assert property (@(posedge clk) disable iff (sys_rst)
    write_busy |-> !sda_oe) else $error("acknowledge during write cycle");
  busy_cause_a : assert property (@(posedge clk) disable iff (sys_rst)
    $rose(write_busy) |-> stop_age_r < 6'h28) else $error("write cycle without Stop");
  busy_len_a : assert property (@(posedge clk) disable iff (sys_rst)
    $fell(write_busy) |-> busy_cnt_r <= WRITE_CYCLES && busy_cnt_r + 2 >= WRITE_CYCLES)
    else $error("write cycle length wrong");
  // Main scenarios reached
  busy_seen_c : cover property (@(posedge clk) disable iff (sys_rst) $rose(write_busy));
  busy_end_c : cover property (@(posedge clk) disable iff (sys_rst) $fell(write_busy));
  drive_seen_c : cover property (@(posedge link_clk) disable iff (sys_rst) $rose(sda_oe));
endmodule : eecl_client_checker
bind eecl_client eecl_client_checker #(.WRITE_CYCLES(WRITE_CYCLES), .DEV_CODE(DEV_CODE)) chk (
  .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i), .wp_i(wp_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .write_busy(write_busy));
`default_nettype wire

/* File: tb/eecl_host.sv */
// Host model: drives SCL and an open-drain SDA from link_clk edges.
// Assumes the bench resolves the SDA wire with a pull-up and returns it on sda_w.
`timescale 1ns/10ps
`default_nettype none
module eecl_host (
  input  wire logic link_clk, // Link sampling clock
  input  wire logic sda_w,    // Resolved SDA wire
  output var  logic scl_o,    // SCL, idles high and stands still outside frames
  output var  logic sda_o     // SDA drive, 1 releases to the pull-up
);
  // Bus idle at power-up
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Wait n link clocks
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask : tick
  // Start or repeated Start; slack lets the device release a pending ack first
  task automatic start();
    sda_o <= 1'b1;
    tick(6);
    scl_o <= 1'b1;
    tick(6);
    sda_o <= 1'b0;
    tick(6);
    scl_o <= 1'b0;
    tick(6);
  endtask : start
  // Stop, leaving the bus idle
  task automatic stop();
    sda_o <= 1'b0;
    tick(6);
    scl_o <= 1'b1;
    tick(6);
    sda_o <= 1'b1;
    tick(6);
  endtask : stop
  // One bit: change in SCL low, sample mid high
  task automatic bit_io(input logic b, output logic s);
    sda_o <= b;
    tick(10);
    scl_o <= 1'b1;
    tick(5);
    s = sda_w;
    tick(5);
    scl_o <= 1'b0;
    tick(2);
  endtask : bit_io
  // Eight bits MSB first, then the ninth pulse carrying ack
  task automatic byte_io(input logic [7:0] d, input logic ack, output logic [7:0] q, output logic s);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack, s);
  endtask : byte_io
endmodule : eecl_host
`default_nettype wire

/* File: tb/eecl_client_tb.sv */
// Bench: host model and an expected-memory model checked at every read byte, every wr ack and each read control ack.
// Assumes design files, checker and host model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module eecl_client_tb;
  localparam logic [3:0] DEV_CODE = 4'h9; // Device type code, value arbitrary
  logic       clk, link_clk, sys_rst, wp_i; // Driven inputs
  wire  logic host_scl, host_sda;           // Host pins
  wire  logic dev_sda, sda_oe, write_busy;  // Device outputs
  wire  logic sda_w;                        // Resolved SDA, pull-up when released
  logic [7:0] mem_m [512];                  // Expected array
  int         ptr_m;                        // Expected pointer
  int         seed = 32'hF9C4;
  int         n_fail = 0;
  int         n_checks = 0;
  logic [7:0] a, q;
  logic       r;
  assign sda_w = host_sda & (sda_oe ? dev_sda : 1'b1);
  // Long write cycle so the first poll lands inside it
  eecl_client #(.WRITE_CYCLES(2000), .DEV_CODE(DEV_CODE)) dut (.clk(clk), .sys_rst(sys_rst),
    .link_clk(link_clk), .scl_i(host_scl), .sda_i(sda_w), .wp_i(wp_i), .sda_o(dev_sda),
    .sda_oe(sda_oe), .write_busy(write_busy));
  eecl_host host (.link_clk(link_clk), .sda_w(sda_w), .scl_o(host_scl), .sda_o(host_sda));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Link clock offset so its edges never line up with clk
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Poll with write control bytes until acked; bounded
  task automatic poll(input logic busy_exp);
    int k;
    k = 0;
    r = 1'b1;
    while (r && k < 20) begin
      host.start();
      host.byte_io({DEV_CODE, 4'h0}, 1'b1, q, r);
      host.stop();
      if (k == 0) begin
        check("first poll", {7'h00, busy_exp}, {7'h00, r});
        check("busy flag", {7'h00, busy_exp}, {7'h00, write_busy});
      end
      k++;
    end
    check("busy after ack", 8'h00, {7'h00, write_busy});
    if (r) begin
      n_fail++;
      $display("mismatch poll expected ack seen none");
      report_and_stop();
    end
  endtask : poll
  // Page write of n random bytes, Stop, then poll
  task automatic wr(input logic blk, input logic [7:0] adr, input int n);
    logic [7:0] d;
    host.start();
    host.byte_io({DEV_CODE, 2'b00, blk, 1'b0}, 1'b1, q, r);
    check("ctl ack", 8'h00, {7'h00, r});
    host.byte_io(adr, 1'b1, q, r);
    check("adr ack", 8'h00, {7'h00, r});
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      host.byte_io(d, 1'b1, q, r);
      check("data ack", 8'h00, {7'h00, r});
      if (!(wp_i && blk)) mem_m[{blk, adr[7:4], 4'(adr[3:0] + i)}] = d;
    end
    host.stop();
    ptr_m = {blk, adr[7:4], 4'(adr[3:0] + n)};
    poll(!(wp_i && blk));
  endtask : wr
  // Read n bytes; set loads the pointer by a write header and repeated Start
  task automatic rd(input logic blk, input logic [7:0] adr, input int n, input logic set);
    if (set) begin
      host.start();
      host.byte_io({DEV_CODE, 2'b00, blk, 1'b0}, 1'b1, q, r);
      host.byte_io(adr, 1'b1, q, r);
      ptr_m = {blk, adr};
    end else ptr_m = (ptr_m % 256) + (blk ? 256 : 0);
    host.start();
    host.byte_io({DEV_CODE, 2'b00, blk, 1'b1}, 1'b1, q, r);
    check("read ctl ack", 8'h00, {7'h00, r});
    for (int i = 0; i < n; i++) begin
      host.byte_io(8'hFF, i == n - 1, q, r);
      check("read data", mem_m[ptr_m], q);
      ptr_m = (ptr_m + 1) % 512;
    end
    host.tick(6);
    check("nack release", 8'h01, {7'h00, sda_w});
    host.stop();
  endtask : rd
  initial begin
    sys_rst = 1'b1;
    wp_i = 1'b0;
    foreach (mem_m[i]) mem_m[i] = 8'h00;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    host.tick(10);
    // Foreign type code: no ack, then deaf
    host.start();
    host.byte_io({DEV_CODE ^ 4'h1, 4'h0}, 1'b1, q, r);
    check("foreign ack", 8'h01, {7'h00, r});
    host.byte_io(8'h00, 1'b1, q, r);
    check("deaf ack", 8'h01, {7'h00, r});
    host.stop();
    $display("test foreign done");
    // Byte write and read back over both blocks and both protect levels
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) wp_i <= k[1];
      a = 8'($random(seed));
      wr(k[0], a, 1);
      rd(k[0], a, 1, 1'b1);
    end
    @(posedge clk) wp_i <= 1'b0;
    $display("test byte protect done");
    // Eighteen bytes wrap inside one page, then a current-address read
    wr(1'b1, 8'hF6, 18);
    rd(1'b1, 8'h00, 1, 1'b0);
    $display("test page wrap done");
    // Write abandoned by repeated Start leaves memory untouched
    host.start();
    host.byte_io({DEV_CODE, 4'h0}, 1'b1, q, r);
    host.byte_io(8'h20, 1'b1, q, r);
    host.byte_io(~mem_m[32], 1'b1, q, r);
    rd(1'b0, 8'h20, 1, 1'b1);
    // Sequential read across pages and across the block boundary
    rd(1'b0, 8'hFA, 12, 1'b1);
    $display("test reads done");
    report_and_stop();
  end
endmodule : eecl_client_tb
`default_nettype wire
